// >>> banked_data_memory_map.sv
// Banked data memory: special function registers and general purpose RAM
// Behaviour
// - Status bit five selects bank 1 when set, bank 0 when clear.
// - Lowest 32 addresses of each bank hold special registers; storage above.
// - Largest build has RAM at 20h-7Fh bank 0 and A0h-BFh bank 1.
// - Bank 1 F0h-FFh reaches the same cells as bank 0 70h-7Fh.
// - RAM capacity is a parameter of 80, 96 or 128 bytes.
// - Every RAM byte reachable directly or through the indirect pointer.
// - All special registers including program counter low are read/write mapped.
// - The working register has no data memory address.
// - Enable register bit 6 at 8Ch enables comparator interrupt; resets 0.
// - Flags set on their event regardless of any enable bit.
// - Unimplemented interrupt enable bits ignore writes and read zero.
// - Flag register bit 6 at 0Ch is the comparator change flag.
`default_nettype none
module banked_data_memory_map
  import data_memory_pkg::*;
#(
  parameter int gpr_bytes = 128
) (
  input  wire logic     clock,
  input  wire logic     rst,
  input  wire mem_req_s req,
  output logic [7:0]    rdata,
  input  wire logic     comparator_changed,
  input  wire logic [7:0] timer_zero_in,
  input  wire logic [7:0] port_a_in,
  input  wire logic [7:0] port_b_in,
  input  wire logic [7:0] program_counter_low_in,
  output logic          program_counter_low_write,
  output logic [7:0]    program_counter_low_wdata,
  output logic [7:0]    core_status,
  output logic [7:0]    indirect_pointer,
  output logic [7:0]    program_counter_high_latch,
  output logic [7:0]    interrupt_control,
  output logic [7:0]    peripheral_irq_flags,
  output logic [7:0]    peripheral_irq_enables,
  output logic [7:0]    timer_prescaler_options,
  output logic [7:0]    port_a_direction,
  output logic [7:0]    port_b_direction,
  output logic [7:0]    port_a_out,
  output logic [7:0]    port_b_out,
  output logic          timer_zero_write,
  output logic [7:0]    power_control,
  output logic [7:0]    comparator_control,
  output logic [7:0]    voltage_reference_control,
  output logic          comparator_irq_request
);

  // Effective address: bank bit over direct offset, or the pointer itself;
  // a direct access to the access port offset goes through the pointer in either bank
  wire logic       bank_select_bit = core_status[bank_select_pos];
  wire logic [7:0] direct_full     = {bank_select_bit, req.direct_addr};
  wire logic       port_offset     = (req.direct_addr == indirect_access_port_addr[6:0]);
  wire logic       via_port        = req.indirect || port_offset;
  wire logic [7:0] eff_addr        = via_port ? indirect_pointer : direct_full;
  // The access port itself is no physical register; pointing it at itself reads 0
  wire logic       self_loop = via_port && (indirect_pointer[6:0] == 7'h00);
  wire logic [6:0] off       = eff_addr[6:0];
  wire logic       bank1     = eff_addr[7];
  wire logic       is_sfr    = (off < 7'(sfr_count));

  // RAM index decode; the common window folds onto bank 0 70h-7Fh
  localparam int ram_depth = 128;
  wire logic in_b0  = !bank1 && (eff_addr >= gpr_bank0_lo) && (eff_addr <= gpr_bank0_hi);
  wire logic in_b1  = bank1 && (eff_addr >= gpr_bank1_lo) && (eff_addr <= gpr_bank1_hi);
  wire logic in_cm  = bank1 && (eff_addr >= common_lo) && (gpr_bytes > 80);
  wire logic [6:0] cm_idx = 7'(common_alias_lo - gpr_bank0_lo) + {3'h0, eff_addr[3:0]};
  wire logic [6:0] b0_idx = 7'(eff_addr - gpr_bank0_lo);
  wire logic [6:0] b1_idx = 7'(eff_addr - gpr_bank1_lo) + 7'h60;
  wire logic [6:0] ram_idx = in_cm ? cm_idx : (in_b0 ? b0_idx : b1_idx);
  // Capacity limits: 80 bytes stop bank 0 at 6Fh, 96 fill bank 0, 128 add bank 1
  wire logic ram_hit = !self_loop && (in_cm ||
                       (in_b0 && (int'(b0_idx) < gpr_bytes) && (gpr_bytes <= 96 ||
                        int'(b0_idx) < 96)) ||
                       (in_b1 && gpr_bytes == 128));

  // Register hit flags; shared ones ignore the bank bit
  wire logic any_bank = is_sfr && !self_loop;
  wire logic hit_pcl  = any_bank && off == program_counter_low_addr[6:0];
  wire logic hit_stat = any_bank && off == core_status_addr[6:0];
  wire logic hit_ptr  = any_bank && off == indirect_pointer_addr[6:0];
  wire logic hit_pch  = any_bank && off == program_counter_high_latch_addr[6:0];
  wire logic hit_icon = any_bank && off == interrupt_control_addr[6:0];
  wire logic b0       = any_bank && !bank1;
  wire logic b1       = any_bank && bank1;
  wire logic hit_tmr  = b0 && off == timer_zero_count_addr[6:0];
  wire logic hit_pa   = b0 && off == port_a_pins_addr[6:0];
  wire logic hit_pb   = b0 && off == port_b_pins_addr[6:0];
  wire logic hit_pir  = b0 && off == peripheral_irq_flags_addr[6:0];
  wire logic hit_cmc  = b0 && off == comparator_control_addr[6:0];
  wire logic hit_opt  = b1 && off == timer_prescaler_options_addr[6:0];
  wire logic hit_tra  = b1 && off == port_a_direction_addr[6:0];
  wire logic hit_trb  = b1 && off == port_b_direction_addr[6:0];
  wire logic hit_pie  = b1 && off == peripheral_irq_enables_addr[6:0];
  wire logic hit_power_control = b1 && off == power_control_addr[6:0];
  wire logic hit_vrc  = b1 && off == voltage_reference_control_addr[6:0];
  wire logic wr       = req.write;

  // General purpose storage in flip-flops
  logic [7:0] ram [ram_depth];
  always_ff @(posedge clock) begin
    if (wr && ram_hit) begin
      ram[ram_idx] <= req.wdata;
    end
  end

  // Comparator flag: the event wins over a clearing write
  wire logic [7:0] flag_wr  = hit_pir && wr ? (req.wdata & irq_bits_mask) : peripheral_irq_flags;
  wire logic [7:0] flag_set = comparator_changed ? irq_bits_mask : 8'h00;
  wire logic [7:0] next_peripheral_irq_flags = flag_wr | flag_set;

  // Comparator flag register; every cycle takes the merged write and event
  always_ff @(posedge clock) begin
    if (rst) begin
      peripheral_irq_flags <= irq_flags_reset;
    end else begin
      peripheral_irq_flags <= next_peripheral_irq_flags;
    end
  end

  // Special registers; the mask keeps unimplemented bits at zero
  masked_register #(
    .reset_value (plain_reset),
    .write_mask  (full_mask)
  ) i_core_status (
    .clock       (clock),
    .rst         (rst),
    .load        (wr && hit_stat),
    .wdata       (req.wdata),
    .value       (core_status)
  );
  masked_register #(
    .reset_value (plain_reset),
    .write_mask  (full_mask)
  ) i_indirect_pointer (
    .clock       (clock),
    .rst         (rst),
    .load        (wr && hit_ptr),
    .wdata       (req.wdata),
    .value       (indirect_pointer)
  );
  masked_register #(
    .reset_value (plain_reset),
    .write_mask  (full_mask)
  ) i_program_counter_high_latch (
    .clock       (clock),
    .rst         (rst),
    .load        (wr && hit_pch),
    .wdata       (req.wdata),
    .value       (program_counter_high_latch)
  );
  masked_register #(
    .reset_value (plain_reset),
    .write_mask  (full_mask)
  ) i_interrupt_control (
    .clock       (clock),
    .rst         (rst),
    .load        (wr && hit_icon),
    .wdata       (req.wdata),
    .value       (interrupt_control)
  );
  masked_register #(
    .reset_value (irq_enables_reset),
    .write_mask  (irq_bits_mask)
  ) i_peripheral_irq_enables (
    .clock       (clock),
    .rst         (rst),
    .load        (wr && hit_pie),
    .wdata       (req.wdata),
    .value       (peripheral_irq_enables)
  );
  masked_register #(
    .reset_value (options_reset),
    .write_mask  (full_mask)
  ) i_timer_prescaler_options (
    .clock       (clock),
    .rst         (rst),
    .load        (wr && hit_opt),
    .wdata       (req.wdata),
    .value       (timer_prescaler_options)
  );
  masked_register #(
    .reset_value (port_a_direction_reset),
    .write_mask  (port_a_direction_mask)
  ) i_port_a_direction (
    .clock       (clock),
    .rst         (rst),
    .load        (wr && hit_tra),
    .wdata       (req.wdata),
    .value       (port_a_direction)
  );
  masked_register #(
    .reset_value (direction_reset),
    .write_mask  (full_mask)
  ) i_port_b_direction (
    .clock       (clock),
    .rst         (rst),
    .load        (wr && hit_trb),
    .wdata       (req.wdata),
    .value       (port_b_direction)
  );
  masked_register #(
    .reset_value (plain_reset),
    .write_mask  (full_mask)
  ) i_port_a_out (
    .clock       (clock),
    .rst         (rst),
    .load        (wr && hit_pa),
    .wdata       (req.wdata),
    .value       (port_a_out)
  );
  masked_register #(
    .reset_value (plain_reset),
    .write_mask  (full_mask)
  ) i_port_b_out (
    .clock       (clock),
    .rst         (rst),
    .load        (wr && hit_pb),
    .wdata       (req.wdata),
    .value       (port_b_out)
  );
  masked_register #(
    .reset_value (plain_reset),
    .write_mask  (full_mask)
  ) i_power_control (
    .clock       (clock),
    .rst         (rst),
    .load        (wr && hit_power_control),
    .wdata       (req.wdata),
    .value       (power_control)
  );
  masked_register #(
    .reset_value (plain_reset),
    .write_mask  (comparator_control_mask)
  ) i_comparator_control (
    .clock       (clock),
    .rst         (rst),
    .load        (wr && hit_cmc),
    .wdata       (req.wdata),
    .value       (comparator_control)
  );
  masked_register #(
    .reset_value (plain_reset),
    .write_mask  (voltage_reference_mask)
  ) i_voltage_reference_control (
    .clock       (clock),
    .rst         (rst),
    .load        (wr && hit_vrc),
    .wdata       (req.wdata),
    .value       (voltage_reference_control)
  );

  // Write strobes to registers kept by the core and timer
  assign program_counter_low_write = wr && hit_pcl;
  assign program_counter_low_wdata = req.wdata;
  assign timer_zero_write          = wr && hit_tmr;
  // Enabled comparator request, further gated by the global enable
  assign comparator_irq_request = peripheral_irq_flags[comparator_irq_pos] &&
                                  peripheral_irq_enables[comparator_irq_pos] &&
                                  interrupt_control[global_irq_enable_pos];

  // Read mux; no address selects a working register, unmapped reads give 0
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (ram_hit) next_rdata = ram[ram_idx];
    else if (hit_pcl) next_rdata = program_counter_low_in;
    else if (hit_stat) next_rdata = core_status;
    else if (hit_ptr) next_rdata = indirect_pointer;
    else if (hit_pch) next_rdata = program_counter_high_latch;
    else if (hit_icon) next_rdata = interrupt_control;
    else if (hit_tmr) next_rdata = timer_zero_in;
    else if (hit_pa) next_rdata = port_a_in;
    else if (hit_pb) next_rdata = port_b_in;
    else if (hit_pir) next_rdata = peripheral_irq_flags & irq_bits_mask;
    else if (hit_cmc) next_rdata = comparator_control;
    else if (hit_opt) next_rdata = timer_prescaler_options;
    else if (hit_tra) next_rdata = port_a_direction;
    else if (hit_trb) next_rdata = port_b_direction;
    else if (hit_pie) next_rdata = peripheral_irq_enables & irq_bits_mask;
    else if (hit_power_control) next_rdata = power_control;
    else if (hit_vrc) next_rdata = voltage_reference_control;
  end

  // Registered read data, one cycle after the read request
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= plain_reset;
    end else if (req.read) begin
      rdata <= next_rdata;
    end
  end

endmodule // banked_data_memory_map

// One special register: loads masked write data, resets to a fixed value
module masked_register #(
  parameter logic [7:0] reset_value = 8'h00,
  parameter logic [7:0] write_mask  = 8'hff
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [7:0] wdata,
  output logic [7:0]      value
);
  // Bits outside the mask never load, so unimplemented bits read as 0
  always_ff @(posedge clock) begin
    if (rst) begin
      value <= reset_value;
    end else if (load) begin
      value <= wdata & write_mask;
    end
  end
endmodule // masked_register
`default_nettype wire

// >>> data_memory_pkg.sv
// Package for the banked data memory map: offsets, fields, reset values
`default_nettype none
package data_memory_pkg;
  // Register offsets within a bank (low seven address bits) or full address
  localparam logic [7:0] indirect_access_port_addr       = 8'h00;
  localparam logic [7:0] timer_zero_count_addr           = 8'h01;
  localparam logic [7:0] program_counter_low_addr        = 8'h02;
  localparam logic [7:0] core_status_addr                = 8'h03;
  localparam logic [7:0] indirect_pointer_addr           = 8'h04;
  localparam logic [7:0] port_a_pins_addr                = 8'h05;
  localparam logic [7:0] port_b_pins_addr                = 8'h06;
  localparam logic [7:0] program_counter_high_latch_addr = 8'h0a;
  localparam logic [7:0] interrupt_control_addr          = 8'h0b;
  localparam logic [7:0] peripheral_irq_flags_addr       = 8'h0c;
  localparam logic [7:0] comparator_control_addr         = 8'h1f;
  localparam logic [7:0] timer_prescaler_options_addr    = 8'h81;
  localparam logic [7:0] port_a_direction_addr           = 8'h85;
  localparam logic [7:0] port_b_direction_addr           = 8'h86;
  localparam logic [7:0] peripheral_irq_enables_addr     = 8'h8c;
  localparam logic [7:0] power_control_addr              = 8'h8e;
  localparam logic [7:0] voltage_reference_control_addr  = 8'h9f;
  // Map layout
  localparam int         sfr_count        = 32;
  localparam logic [7:0] gpr_bank0_lo     = 8'h20;
  localparam logic [7:0] gpr_bank0_hi     = 8'h7f;
  localparam logic [7:0] gpr_bank1_lo     = 8'ha0;
  localparam logic [7:0] gpr_bank1_hi     = 8'hbf;
  localparam logic [7:0] common_lo        = 8'hf0;
  localparam logic [7:0] common_hi        = 8'hff;
  localparam logic [7:0] common_alias_lo  = 8'h70;
  // Field positions
  localparam int bank_select_pos        = 5;
  localparam int global_irq_enable_pos  = 7;
  localparam int comparator_irq_pos     = 6;
  // Implemented bit masks and reset values
  localparam logic [7:0] irq_bits_mask     = 8'h40;
  localparam logic [7:0] irq_enables_reset = 8'h00;
  localparam logic [7:0] irq_flags_reset   = 8'h00;
  localparam logic [7:0] plain_reset       = 8'h00;
  localparam logic [7:0] options_reset     = 8'hff;
  localparam logic [7:0] direction_reset   = 8'hff;
  // Port A has five pins; its upper direction bits are unimplemented
  localparam logic [7:0] port_a_direction_reset = 8'h1f;
  localparam logic [7:0] port_a_direction_mask  = 8'h1f;
  // Writable bits; comparator outputs and spare bits read back as zero here
  localparam logic [7:0] full_mask               = 8'hff;
  localparam logic [7:0] comparator_control_mask = 8'h0f;
  localparam logic [7:0] voltage_reference_mask  = 8'hef;
  // One data memory access from the core
  typedef struct packed {
    logic       read;
    logic       write;
    logic       indirect;
    logic [6:0] direct_addr;
    logic [7:0] wdata;
  } mem_req_s;
endpackage : data_memory_pkg
`default_nettype wire

// >>> dm_checker.sv
// Assertion checker for the banked data memory map ports
`default_nettype none
module dm_checker
  import data_memory_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire mem_req_s   req,
  input wire logic [7:0] rdata,
  input wire logic       comparator_changed,
  input wire logic       program_counter_low_write,
  input wire logic [7:0] program_counter_low_wdata,
  input wire logic [7:0] core_status,
  input wire logic [7:0] interrupt_control,
  input wire logic [7:0] peripheral_irq_flags,
  input wire logic [7:0] peripheral_irq_enables,
  input wire logic       timer_zero_write,
  input wire logic       comparator_irq_request
);
  timeunit 1ns;
  timeprecision 1ns;
  // Shared clock for every check; reset disables every check except a_reset_clear
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Direct write to one bank offset
  sequence s_wr(logic [6:0] off);
    req.write && !req.indirect && req.direct_addr == off;
  endsequence
  // Bank bit, enables, flags, strobes and empty locations
  a_bank_select: assert property (s_wr(7'h03) |=> core_status[5] == $past(req.wdata[5]))
    else $error("bank select bit not taken");
  a_enable_write: assert property (core_status[5] ##0 s_wr(7'h0c) |=>
    peripheral_irq_enables == ($past(req.wdata) & irq_bits_mask)) else $error("enable bad");
  a_unused_bits: assert property (((peripheral_irq_enables | peripheral_irq_flags)
    & ~irq_bits_mask) == 8'h00) else $error("unimplemented interrupt bit set");
  a_flag_set: assert property (comparator_changed |=> peripheral_irq_flags[6])
    else $error("comparator flag not set");
  a_irq_request: assert property (comparator_irq_request == (peripheral_irq_flags[6]
    & peripheral_irq_enables[6] & interrupt_control[7])) else $error("request mismatch");
  a_pcl_strobe: assert property (s_wr(7'h02) |-> program_counter_low_write)
    else $error("program counter low strobe missing");
  a_pcl_data: assert property (program_counter_low_write |->
    program_counter_low_wdata == req.wdata) else $error("program counter low data wrong");
  a_timer_strobe: assert property (!core_status[5] ##0 s_wr(7'h01) |-> timer_zero_write)
    else $error("timer strobe missing");
  a_unmapped_read: assert property (req.read && !req.indirect &&
    req.direct_addr inside {7'h07, 7'h08, 7'h0d, 7'h0f, [7'h10:7'h1e]} |=> rdata == 8'h00)
    else $error("unmapped location read nonzero");
  a_reset_clear: assert property (disable iff (1'b0) rst |=> peripheral_irq_enables == 8'h00
    && peripheral_irq_flags == 8'h00) else $error("interrupt registers not reset");
endmodule // dm_checker
// Attach to the design top
bind banked_data_memory_map dm_checker i_checker (.clock(clock), .rst(rst), .req(req),
  .rdata(rdata), .comparator_changed(comparator_changed), .core_status(core_status),
  .program_counter_low_wdata(program_counter_low_wdata),
  .program_counter_low_write(program_counter_low_write), .interrupt_control(interrupt_control),
  .peripheral_irq_flags(peripheral_irq_flags), .peripheral_irq_enables(peripheral_irq_enables),
  .timer_zero_write(timer_zero_write), .comparator_irq_request(comparator_irq_request));
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the banked data memory map
`default_nettype none
module testbench
  import data_memory_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock, rst, chg, irq;
  mem_req_s   req;
  logic [7:0] rdata, status, flags, ctrl, a, d;
  logic [7:0] ins [4];
  logic [7:0] io [4] = '{8'h01, 8'h05, 8'h06, 8'h82};
  logic [15:0] rv [5] = '{16'h81ff, 16'h851f, 16'h86ff, 16'h8c00, 16'h0b00};
  // Register ports, their addresses and writable bits
  logic [7:0] outs [11];
  logic [7:0] wa [11] = '{8'h04, 8'h0a, 8'h81, 8'h85, 8'h86, 8'h8e, 8'h1f, 8'h9f, 8'h8c,
                          8'h05, 8'h06};
  logic [7:0] wm [11] = '{full_mask, full_mask, full_mask, port_a_direction_mask, full_mask,
                          full_mask, comparator_control_mask, voltage_reference_mask,
                          irq_bits_mask, full_mask, full_mask};
  int         mem [256];
  int         error_cnt = 0;
  int         compares = 0;
  banked_data_memory_map i_dut (.clock(clock), .rst(rst), .req(req), .rdata(rdata),
    .comparator_changed(chg), .timer_zero_in(ins[0]), .port_a_in(ins[1]), .port_b_in(ins[2]),
    .program_counter_low_in(ins[3]), .program_counter_low_write(), .program_counter_low_wdata(),
    .core_status(status), .indirect_pointer(outs[0]), .program_counter_high_latch(outs[1]),
    .interrupt_control(ctrl), .peripheral_irq_flags(flags), .peripheral_irq_enables(outs[8]),
    .timer_prescaler_options(outs[2]), .port_a_direction(outs[3]), .port_b_direction(outs[4]),
    .port_a_out(outs[9]), .port_b_out(outs[10]), .timer_zero_write(), .power_control(outs[5]),
    .comparator_control(outs[6]), .voltage_reference_control(outs[7]),
    .comparator_irq_request(irq));
  // Clock
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One request cycle, results settled on return
  task automatic op(input logic r, w, i, input logic [7:0] ad, dt);
    @(posedge clock);
    req <= '{r, w, i, ad[6:0], dt};
    @(posedge clock);
    req <= '0;
    #1;
  endtask
  // Access by full address, setting pointer or bank first
  task automatic acc(input logic w, i, input logic [7:0] ad, dt);
    if (i) op(0, 1, 0, 8'h04, ad);
    else if (status[5] !== ad[7]) op(0, 1, 0, 8'h03, {2'b00, ad[7], 5'h00});
    op(!w, w, i && 1'($urandom), i ? 8'h00 : ad, dt);
  endtask
  // Model: RAM cell behind a full address, -1 where nothing is built
  function automatic int phys(input logic [7:0] ad);
    if (ad inside {[8'h20:8'h7f], [8'ha0:8'hbf]}) return ad;
    if (ad >= 8'hf0) return ad - 8'h80;
    return -1;
  endfunction
  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    conclude();
  end
  // Main sequence
  initial begin
    void'($urandom(32'heb26));
    rst <= 1;
    req <= '0;
    chg <= 0;
    foreach (ins[k]) ins[k] <= 8'($urandom);
    repeat (12) @(posedge clock);
    rst <= 0;
    foreach (rv[k]) begin
      acc(0, 0, rv[k][15:8], 0);
      chk(rdata, rv[k][7:0]);
    end
    foreach (io[k]) begin
      acc(0, 0, io[k], 0);
      chk(rdata, ins[k]);
      acc(1, 0, io[k], 8'($urandom));
    end
    // Writable registers reach their ports and read back; pin reads show the inputs
    foreach (wa[k]) begin
      d = 8'($urandom);
      acc(1, 0, wa[k], d);
      chk(outs[k], d & wm[k]);
      acc(0, 0, wa[k], 0);
      chk(rdata, (k > 8) ? ins[k - 8] : (d & wm[k]));
    end
    repeat (200) begin
      a = {1'($urandom), 7'($urandom_range(127, 32))};
      d = 8'($urandom);
      acc(1, 1'($urandom), a, d);
      if (phys(a) >= 0) mem[phys(a)] = d;
      if (a[6:4] == 3'h7 && $urandom_range(1)) a ^= 8'h80;
      acc(0, 1'($urandom), a, 0);
      chk(rdata, (phys(a) < 0) ? 8'h00 : 8'(mem[phys(a)]));
    end
    foreach (io[k]) begin
      acc(1, 0, {io[k][7], 7'h10 ^ io[k][6:0]}, 8'hff);
      acc(0, 0, {io[k][7], 7'h10 ^ io[k][6:0]}, 0);
      chk(rdata, 8'h00);
    end
    acc(0, 1, 8'h80, 0);
    chk(rdata, 8'h00);
    acc(1, 0, 8'h8c, 8'hff);
    acc(0, 0, 8'h8c, 0);
    chk(rdata, 8'h40);
    acc(0, 0, 8'h0c, 0);
    chk(rdata, 8'h00);
    @(posedge clock);
    chg <= 1;
    req <= '{0, 1, 0, 7'h0c, 8'h00};
    @(posedge clock);
    chg <= 0;
    req <= '0;
    #1 chk(flags, 8'h40);
    chk({7'h00, irq}, 8'h00);
    acc(1, 0, 8'h0b, 8'h80);
    chk(ctrl, 8'h80);
    chk({7'h00, irq}, 8'h01);
    acc(1, 0, 8'h0c, 8'h00);
    chk({flags[7:1], irq}, 8'h00);
    conclude();
  end
endmodule // testbench
`default_nettype wire
